// ==== nvc_pkg.sv ====
package nvc_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [13:0] NVC_IDX_ADDR   = 14'h1C8C;
    localparam logic [13:0] NVC_IDX_DATA   = 14'h1C8E;
    localparam logic [13:0] NVC_IDX_CTRL   = 14'h1C90;
    localparam logic [13:0] NVC_IDX_UNLOCK = 14'h1C91;

    // widths
    localparam int NVC_ADDR_W    = 15;
    localparam int NVC_DATA_W    = 14;
    localparam int NVC_ROW_WORDS = 32;
    localparam int NVC_ROW_IDX_W = 5;

    // control register bit positions
    localparam int NVC_BIT_REGION  = 6;
    localparam int NVC_BIT_LATCH   = 5;
    localparam int NVC_BIT_ERASE   = 4;
    localparam int NVC_BIT_WERR    = 3;
    localparam int NVC_BIT_PEN     = 2;
    localparam int NVC_BIT_WRITE   = 1;
    localparam int NVC_BIT_READ    = 0;

    // reset values and last row-latch index
    localparam logic [14:0] NVC_ADDR_RST   = 15'h0000;
    localparam logic [13:0] NVC_DATA_RST   = 14'h0000;
    localparam logic [7:0]  NVC_UNLOCK_RST = 8'h00;
    localparam logic [13:0] NVC_LATCH_RST  = 14'h3FFF;
    localparam logic [4:0]  NVC_IDX_LAST   = 5'h1F;

    // unlock patterns
    localparam logic [7:0] NVC_KEY_FIRST  = 8'h55;
    localparam logic [7:0] NVC_KEY_SECOND = 8'hAA;

    typedef enum logic [2:0] {
        NVC_OP_NONE,
        NVC_OP_READ,
        NVC_OP_ERASE_ROW,
        NVC_OP_WRITE_ROW,
        NVC_OP_WRITE_WORD
    } nvc_op_t;

    // command towards the array
    typedef struct packed {
        logic        start;
        nvc_op_t     op;
        logic        region;
        logic [14:0] addr;
        logic [13:0] data;
    } nvc_req_t;

    // one row-latch word streamed during a row write
    typedef struct packed {
        logic        valid;
        logic [4:0]  idx;
        logic [13:0] data;
    } nvc_row_t;

    // answer from the array
    typedef struct packed {
        logic        done;
        logic        fail;
        logic [13:0] rdata;
    } nvc_rsp_t;

endpackage

// ==== nvc_ctrl.sv ====
`timescale 1ns/1ps
module nvc_ctrl
    import nvc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // array side
    input  wire logic        write_protect_i,
    input  wire nvc_rsp_t    array_rsp_i,
    output nvc_req_t         array_req_o,
    output nvc_row_t         array_row_o,
    // system side
    output logic             cpu_stall_o,
    output logic             op_done_o
);

    typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_ARMED} nvc_ul_state_t;
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_STREAM, ST_WAIT} nvc_op_state_t;

    nvc_ul_state_t  ul_state_reg;
    nvc_op_state_t  op_state_reg;
    logic [14:0]    addr_reg;
    logic [13:0]    data_reg;
    logic [7:0]     unlock_reg;
    logic           region_reg;
    logic           latch_only_reg;
    logic           erase_reg;
    logic           werr_reg;
    logic           pen_reg;
    logic           wr_reg;
    logic           rd_reg;
    logic           in_rst_reg;
    logic [13:0]    latch_reg [NVC_ROW_WORDS];
    logic [4:0]     stream_idx_reg;
    logic           ack_reg;
    logic [31:0]    dat_reg;
    nvc_req_t       req_reg;
    nvc_row_t       row_reg;
    logic           stall_reg;
    logic           done_reg;

    logic           acc;
    logic           wr_acc;
    logic [13:0]    widx;
    logic           ctrl_wr;
    logic [7:0]     cdat;
    logic           ul_wr;
    logic           ul_broken;
    logic           wr_go;
    logic           start_ok;
    logic           latch_op;
    logic           wp_block;
    logic           mem_start;
    logic           rd_go;
    logic           wait_done;
    logic           read_done;
    nvc_op_t        start_op;

    // bus decode; one access per transfer, taken while ack is low
    assign acc     = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_acc  = acc & wb_we_i;
    assign widx    = wb_adr_i[15:2];
    assign ctrl_wr = wr_acc & (widx == NVC_IDX_CTRL) & wb_sel_i[0];
    assign cdat    = wb_dat_i[7:0];
    assign ul_wr   = wr_acc & (widx == NVC_IDX_UNLOCK) & wb_sel_i[0];

    // any access other than the expected next step breaks the sequence
    assign ul_broken = acc & (((ul_state_reg == UL_KEY1) &
                               ~(ul_wr & (cdat == NVC_KEY_SECOND))) |
                              ((ul_state_reg == UL_ARMED) &
                               ~(ctrl_wr & cdat[NVC_BIT_WRITE])));

    // write start honoured only straight after both keys
    assign wr_go    = acc & (ul_state_reg == UL_ARMED) & ctrl_wr
                      & cdat[NVC_BIT_WRITE];
    assign start_ok = wr_go & cdat[NVC_BIT_PEN] & (op_state_reg == ST_IDLE);

    // written byte carries the mode bits of a read-modify-write of the control register
    assign latch_op  = ~cdat[NVC_BIT_REGION] & ~(erase_reg | cdat[NVC_BIT_ERASE])
                       & cdat[NVC_BIT_LATCH];
    assign wp_block  = write_protect_i & ~latch_op;
    assign mem_start = start_ok & ~wp_block & ~latch_op;
    assign rd_go     = ctrl_wr & cdat[NVC_BIT_READ] & ~wr_go
                       & (op_state_reg == ST_IDLE);
    assign wait_done = (op_state_reg == ST_WAIT) & array_rsp_i.done;
    assign read_done = (op_state_reg == ST_READ) & array_rsp_i.done;

    always_comb begin
        if (erase_reg | cdat[NVC_BIT_ERASE]) begin
            start_op = NVC_OP_ERASE_ROW;
        end else if (cdat[NVC_BIT_REGION]) begin
            start_op = NVC_OP_WRITE_WORD;
        end else begin
            start_op = NVC_OP_WRITE_ROW;
        end
    end

    // unlock sequencer
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ul_state_reg <= UL_IDLE;
        end else if (acc) begin
            case (ul_state_reg)
                UL_IDLE: begin
                    if (ul_wr && cdat == NVC_KEY_FIRST) begin
                        ul_state_reg <= UL_KEY1;
                    end
                end
                UL_KEY1: begin
                    if (ul_wr && cdat == NVC_KEY_SECOND) begin
                        ul_state_reg <= UL_ARMED;
                    end else if (ul_wr && cdat == NVC_KEY_FIRST) begin
                        ul_state_reg <= UL_KEY1;
                    end else begin
                        ul_state_reg <= UL_IDLE;
                    end
                end
                UL_ARMED: begin
                    ul_state_reg <= UL_IDLE;
                end
                default: begin
                    ul_state_reg <= UL_IDLE;
                end
            endcase
        end
    end

    // unlock pattern register keeps the last value written
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            unlock_reg <= NVC_UNLOCK_RST;
        end else if (ul_wr) begin
            unlock_reg <= cdat;
        end
    end

    // address register, byte lanes
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            addr_reg <= NVC_ADDR_RST;
        end else if (wr_acc && widx == NVC_IDX_ADDR) begin
            if (wb_sel_i[0]) begin
                addr_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                addr_reg[14:8] <= wb_dat_i[14:8];
            end
        end
    end

    // data register, byte lanes; loaded by a finished read
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            data_reg <= NVC_DATA_RST;
        end else if (read_done) begin
            data_reg <= array_rsp_i.rdata;
        end else if (wr_acc && widx == NVC_IDX_DATA) begin
            if (wb_sel_i[0]) begin
                data_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                data_reg[13:8] <= wb_dat_i[13:8];
            end
        end
    end

    // plain read/write control bits
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            region_reg     <= 1'b0;
            latch_only_reg <= 1'b0;
            pen_reg        <= 1'b0;
        end else if (ctrl_wr) begin
            region_reg     <= cdat[NVC_BIT_REGION];
            latch_only_reg <= cdat[NVC_BIT_LATCH];
            pen_reg        <= cdat[NVC_BIT_PEN];
        end
    end

    // erase bit: software sets, hardware clears after the erase
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            erase_reg <= 1'b0;
        end else if (ctrl_wr && cdat[NVC_BIT_ERASE]) begin
            erase_reg <= 1'b1;
        end else if (wait_done && req_reg.op == NVC_OP_ERASE_ROW) begin
            erase_reg <= 1'b0;
        end
    end

    // write bit: only hardware clears it, zero writes are ignored
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wr_reg <= 1'b0;
        end else if (mem_start) begin
            wr_reg <= 1'b1;
        end else if (wait_done) begin
            wr_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rd_reg <= 1'b0;
        end else if (rd_go) begin
            rd_reg <= 1'b1;
        end else if (read_done) begin
            rd_reg <= 1'b0;
        end
    end

    // marks the cycles of an active reset, so an error caught at its start is kept
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            in_rst_reg <= 1'b1;
        end else begin
            in_rst_reg <= 1'b0;
        end
    end

    // error flag: set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            if (wr_reg) begin
                werr_reg <= 1'b1;
            end else if (in_rst_reg && werr_reg) begin
                werr_reg <= 1'b1;
            end else begin
                werr_reg <= 1'b0;
            end
        end else if (ul_broken || (start_ok && wp_block)
                     || (wait_done && array_rsp_i.fail)) begin
            werr_reg <= 1'b1;
        end else if (ctrl_wr) begin
            werr_reg <= cdat[NVC_BIT_WERR];
        end
    end

    // row write latches
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NVC_ROW_WORDS; i++) begin
                latch_reg[i] <= NVC_LATCH_RST;
            end
        end else if (wait_done && req_reg.op == NVC_OP_WRITE_ROW) begin
            for (int i = 0; i < NVC_ROW_WORDS; i++) begin
                latch_reg[i] <= NVC_LATCH_RST;
            end
        end else if (start_ok && latch_op) begin
            latch_reg[addr_reg[4:0]] <= data_reg;
        end
    end

    // operation sequencer; the array times each operation itself
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            op_state_reg   <= ST_IDLE;
            req_reg        <= '0;
            row_reg        <= '0;
            stream_idx_reg <= '0;
            stall_reg      <= 1'b0;
            done_reg       <= 1'b0;
        end else begin
            req_reg.start <= 1'b0;
            row_reg.valid <= 1'b0;
            done_reg      <= 1'b0;
            case (op_state_reg)
                ST_IDLE: begin
                    if (mem_start) begin
                        req_reg.start  <= 1'b1;
                        req_reg.op     <= start_op;
                        req_reg.region <= cdat[NVC_BIT_REGION];
                        req_reg.addr   <= addr_reg;
                        req_reg.data   <= data_reg;
                        stall_reg      <= 1'b1;
                        stream_idx_reg <= '0;
                        if (start_op == NVC_OP_WRITE_ROW) begin
                            op_state_reg <= ST_STREAM;
                        end else begin
                            op_state_reg <= ST_WAIT;
                        end
                    end else if (rd_go) begin
                        req_reg.start  <= 1'b1;
                        req_reg.op     <= NVC_OP_READ;
                        req_reg.region <= cdat[NVC_BIT_REGION];
                        req_reg.addr   <= addr_reg;
                        req_reg.data   <= data_reg;
                        stall_reg      <= 1'b1;
                        op_state_reg   <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (array_rsp_i.done) begin
                        stall_reg    <= 1'b0;
                        op_state_reg <= ST_IDLE;
                    end
                end
                ST_STREAM: begin
                    row_reg.valid  <= 1'b1;
                    row_reg.idx    <= stream_idx_reg;
                    row_reg.data   <= latch_reg[stream_idx_reg];
                    stream_idx_reg <= stream_idx_reg + 5'h01;
                    if (stream_idx_reg == NVC_IDX_LAST) begin
                        op_state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (array_rsp_i.done) begin
                        stall_reg    <= 1'b0;
                        done_reg     <= 1'b1;
                        op_state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    op_state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // bus answer: ack one cycle after the access is taken; unmapped reads give zero
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= acc;
            if (acc && !wb_we_i) begin
                case (widx)
                    // bits above address bit 14 read zero, a defined value while busy
                    NVC_IDX_ADDR:   dat_reg <= {17'h0_0000, addr_reg};
                    NVC_IDX_DATA:   dat_reg <= {18'h0_0000, data_reg};
                    NVC_IDX_CTRL:   dat_reg <= {24'h00_0000, 1'b0, region_reg,
                                                latch_only_reg, erase_reg,
                                                werr_reg & ~wr_reg, pen_reg,
                                                wr_reg, rd_reg};
                    NVC_IDX_UNLOCK: dat_reg <= {24'h00_0000, unlock_reg};
                    default:        dat_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_o    = ack_reg;
    assign wb_dat_o    = dat_reg;
    assign array_req_o = req_reg;
    assign array_row_o = row_reg;
    assign cpu_stall_o = stall_reg;
    assign op_done_o   = done_reg;

endmodule

// ==== nvc_checker.sv ====
`timescale 1ns/1ps
module nvc_checker
    import nvc_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    // register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    // array and system side
    input wire logic        write_protect_i,
    input wire nvc_rsp_t    array_rsp_i,
    input wire nvc_req_t    array_req_o,
    input wire nvc_row_t    array_row_o,
    input wire logic        cpu_stall_o,
    input wire logic        op_done_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       tk, cw, ul, go, rgo;
    logic [1:0] key_reg;
    assign tk  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cw  = tk && wb_we_i && wb_adr_i[15:2] == NVC_IDX_CTRL;
    assign ul  = tk && wb_we_i && wb_adr_i[15:2] == NVC_IDX_UNLOCK;
    assign go  = cw && key_reg == 2'h2 && wb_dat_i[NVC_BIT_PEN] && wb_dat_i[NVC_BIT_WRITE];
    assign rgo = cw && wb_dat_i[NVC_BIT_READ];
    // any other access drops a half-entered key
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i)
            key_reg <= 2'h0;
        else if (tk)
            key_reg <= (ul && wb_dat_i[7:0] == NVC_KEY_FIRST) ? 2'h1 :
                (ul && key_reg == 2'h1 && wb_dat_i[7:0] == NVC_KEY_SECOND) ? 2'h2 : 2'h0;
    end
    sequence op_end; array_rsp_i.done && cpu_stall_o; endsequence
    sequence row_go; array_req_o.start && array_req_o.op == NVC_OP_WRITE_ROW; endsequence
    sequence row_first; array_row_o.valid && array_row_o.idx == 5'h00; endsequence
    bus_ack_a: assert property (tk |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not one pulse one cycle after the request");
    write_key_a: assert property (array_req_o.start
        && array_req_o.op != NVC_OP_READ |-> $past(go))
        else $error("write started without key, enable and write bit");
    read_start_a: assert property (array_req_o.start
        && array_req_o.op == NVC_OP_READ |-> $past(rgo))
        else $error("read started without read bit");
    no_enable_a: assert property (cw && !wb_dat_i[NVC_BIT_PEN]
        && !wb_dat_i[NVC_BIT_READ] |=> !array_req_o.start)
        else $error("operation started with enable clear");
    protect_a: assert property (go && write_protect_i
        && !wb_dat_i[NVC_BIT_LATCH] |=> !array_req_o.start)
        else $error("protected target was written");
    stall_hold_a: assert property (array_req_o.start
        |-> cpu_stall_o ##1 (cpu_stall_o && !array_req_o.start))
        else $error("stall missing or start repeated during operation");
    op_end_a: assert property (op_end
        |=> !cpu_stall_o && op_done_o == (array_req_o.op != NVC_OP_READ))
        else $error("completion not handled");
    done_pulse_a: assert property (op_done_o |=> !op_done_o)
        else $error("done longer than one cycle");
    row_start_a: assert property (row_go |=> row_first)
        else $error("row stream does not start at word 0");
    row_step_a: assert property (array_row_o.valid && array_row_o.idx != NVC_IDX_LAST
        |=> array_row_o.valid && array_row_o.idx == $past(array_row_o.idx) + 5'h01)
        else $error("row stream broken");
endmodule
bind nvc_ctrl nvc_checker u_chk (.ref_clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_i, .wb_ack_o, .write_protect_i, .array_rsp_i, .array_req_o,
    .array_row_o, .cpu_stall_o, .op_done_o);

// ==== nvc_array_model.sv ====
`timescale 1ns/1ps
module nvc_array_model
    import nvc_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // command in, answer out
    input  wire nvc_req_t   req_i,
    input  wire logic       fail_i,
    input  wire logic [7:0] lat_i,
    output nvc_rsp_t        rsp_o
);
    logic [8:0] cnt_reg;
    logic       busy_reg;
    // row writes wait out the 32-word stream before the timer runs
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            busy_reg <= 1'b0;
            cnt_reg  <= 9'h000;
            rsp_o    <= '0;
        end else begin
            rsp_o.done  <= 1'b0;
            rsp_o.fail  <= 1'b0;
            // data means nothing outside done, so it never sits still
            rsp_o.rdata <= ~rsp_o.rdata;
            if (req_i.start) begin
                busy_reg <= 1'b1;
                cnt_reg  <= {1'b0, lat_i} + ((req_i.op == NVC_OP_WRITE_ROW) ? 9'h022 : 9'h000);
            end else if (busy_reg && cnt_reg == 9'h000) begin
                busy_reg    <= 1'b0;
                rsp_o.done  <= 1'b1;
                rsp_o.fail  <= fail_i;
                rsp_o.rdata <= req_i.addr[13:0] ^ 14'h1555;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 9'h001;
            end
        end
    end
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import nvc_pkg::*;
    localparam logic [15:0] a_adr = {NVC_IDX_ADDR, 2'b00};
    localparam logic [15:0] a_dat = {NVC_IDX_DATA, 2'b00};
    localparam logic [15:0] a_ctl = {NVC_IDX_CTRL, 2'b00};
    localparam logic [15:0] a_unl = {NVC_IDX_UNLOCK, 2'b00};
    logic        clk, rst_n, cyc, stb, we, wp, fail, ack, stall, odone;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat, rdat;
    logic [7:0]  lat;
    logic [14:0] ad;
    logic [13:0] dv;
    nvc_rsp_t    rsp;
    nvc_req_t    req;
    nvc_row_t    row;
    int          errors, n_checks, n_done, cyc_n;
    logic [31:0] rq[$];
    logic [31:0] oq[$];
    logic [13:0] lt[32];
    logic [7:0]  mc[4] = '{8'h16, 8'h56, 8'h46, 8'h06};
    nvc_op_t     mo[4] = '{NVC_OP_ERASE_ROW, NVC_OP_ERASE_ROW,
                           NVC_OP_WRITE_WORD, NVC_OP_WRITE_ROW};

    nvc_ctrl dut (.ref_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .write_protect_i(wp), .array_rsp_i(rsp), .array_req_o(req),
        .array_row_o(row), .cpu_stall_o(stall), .op_done_o(odone));
    nvc_array_model u_arr (.ref_clk_i(clk), .rst_n_i(rst_n), .req_i(req), .fail_i(fail),
        .lat_i(lat), .rsp_o(rsp));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // for a read, d is the value expected back
    task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
        if (!w) rq.push_back(d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= a[6] ? 4'h1 : 4'h3;
        dat <= w ? d : 32'h0;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic idle;
        for (int i = 0; i < 400 && stall !== 1'b0; i++) @(posedge clk);
    endtask

    task automatic sa;
        ad = 15'($urandom);
        wb(1'b1, a_adr, 32'(ad));
    endtask

    task automatic unl;
        wb(1'b1, a_unl, 32'(NVC_KEY_FIRST));
        wb(1'b1, a_unl, 32'(NVC_KEY_SECOND));
    endtask

    task automatic op(input logic [7:0] c, input nvc_op_t o, input logic s, input logic [7:0] af);
        int d;
        d = n_done;
        unl();
        if (s) oq.push_back(32'({o, c[NVC_BIT_REGION], ad}));
        wb(1'b1, a_ctl, 32'(c));
        if (s) begin
            wb(1'b0, a_ctl, 32'(c & 8'hF7));
            wb(1'b1, a_ctl, 32'h0);
        end
        idle();
        wb(1'b0, a_ctl, 32'(af));
        chk("done_count", 32'(n_done - d), 32'(s && o != NVC_OP_READ));
        if (o == NVC_OP_WRITE_ROW) lt = '{default: NVC_LATCH_RST};
    endtask

    task automatic rop(input logic r, input logic e);
        oq.push_back(32'({NVC_OP_READ, r, ad}));
        wb(1'b1, a_ctl, 32'({r, 2'b00, e, 3'b001}));
        idle();
        dv = ad[13:0] ^ 14'h1555;
        wb(1'b0, a_dat, 32'(dv));
        wb(1'b0, a_ctl, 32'({r, 2'b00, e, 3'b000}));
    endtask

    always @(posedge clk) begin
        if (rst_n) begin
            cyc_n++;
            if (cyc_n > 20000) begin
                errors++;
                report_and_stop();
            end
            if (ack && !we) chk("read_data", rdat, rq.pop_front());
            if (req.start && oq.size() == 0) chk("unexpected_start", 32'h1, 32'h0);
            else if (req.start)
                chk("command", 32'({req.op, req.region, req.addr}), oq.pop_front());
            if (req.start && req.op == NVC_OP_WRITE_WORD)
                chk("word_data", 32'(req.data), 32'(dv));
            if (row.valid) chk("row_word", 32'(row.data), 32'(lt[row.idx]));
            if (odone) n_done++;
        end
    end

    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 16'h0;
        sel = 4'h0;
        dat = 32'h0;
        wp = 1'b0;
        fail = 1'b0;
        lat = 8'h40;
        ad = 15'h0;
        dv = 14'h0;
        errors = 0;
        n_checks = 0;
        n_done = 0;
        cyc_n = 0;
        lt = '{default: NVC_LATCH_RST};
        void'($urandom(46566));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wb(1'b0, a_adr, 32'h0);
        wb(1'b0, a_dat, 32'h0);
        wb(1'b0, a_ctl, 32'h0);
        wb(1'b1, 16'h7000, 32'hFFFF_FFFF);
        wb(1'b0, 16'h7000, 32'h0);
        wb(1'b1, a_adr, 32'hFFFF);
        wb(1'b0, a_adr, 32'h7FFF);
        wb(1'b1, a_dat, 32'hFFFF);
        wb(1'b0, a_dat, 32'h3FFF);
        $display("end registers");
        for (int i = 0; i < 4; i++) begin
            sa();
            rop(i[0], 1'b0);
        end
        $display("end reads");
        for (int i = 0; i < 4; i++) begin
            sa();
            op(mc[i], mo[i], 1'b1, 8'h00);
        end
        $display("end modes");
        for (int i = 0; i < 3; i++) begin
            sa();
            dv = 14'($urandom);
            wb(1'b1, a_dat, 32'(dv));
            lt[ad[4:0]] = dv;
            op(8'h26, NVC_OP_NONE, 1'b0, 8'h24);
        end
        op(8'h06, NVC_OP_WRITE_ROW, 1'b1, 8'h00);
        op(8'h06, NVC_OP_WRITE_ROW, 1'b1, 8'h00);
        $display("end row write");
        op(8'h02, NVC_OP_NONE, 1'b0, 8'h00);
        wp <= 1'b1;
        op(8'h06, NVC_OP_NONE, 1'b0, 8'h0C);
        wp <= 1'b0;
        rop(1'b0, 1'b1);
        wb(1'b1, a_ctl, 32'h0);
        wb(1'b0, a_ctl, 32'h0);
        wb(1'b1, a_ctl, 32'h8);
        wb(1'b0, a_ctl, 32'h8);
        wb(1'b1, a_ctl, 32'h0);
        $display("end error flag");
        wb(1'b1, a_unl, 32'(NVC_KEY_FIRST));
        wb(1'b0, a_unl, 32'(NVC_KEY_FIRST));
        wb(1'b1, a_unl, 32'(NVC_KEY_SECOND));
        wb(1'b0, a_ctl, 32'h08);
        wb(1'b1, a_ctl, 32'h06);
        wb(1'b0, a_ctl, 32'h04);
        wb(1'b1, a_ctl, 32'h0);
        fail <= 1'b1;
        sa();
        op(8'h46, NVC_OP_WRITE_WORD, 1'b1, 8'h08);
        fail <= 1'b0;
        wb(1'b1, a_ctl, 32'h0);
        $display("end faults");
        lat <= 8'hC8;
        unl();
        oq.push_back(32'({NVC_OP_ERASE_ROW, 1'b0, ad}));
        wb(1'b1, a_ctl, 32'h16);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wb(1'b0, a_ctl, 32'h08);
        $display("end reset in write");
        report_and_stop();
    end
endmodule
